// ---- rtl/sfc_config_regs.sv ----
/*
  configuration-register command handling of a serial nor flash: read and
  write of the configure register, status register writes with a self-timed
  busy cycle, and read/write of the read tuning register.
  assumes cs_n, sclk, si, wp_n and the shared hold/reset pin arrive
  asynchronously and that sclk is slow enough (8 mclk or more per period)
  for mclk to see every edge.
*/
// Contract
// - opcode 15h shifts out the configure byte, allowed even while busy.
// - configure bit 7 picks hold (0) or reset (1) for the shared pin.
// - quad enable turns off hold and reset on the shared pin.
// - drive strength code: 00 100%, 01 150%, 10 200% default, 11 50%.
// - page size code: 00 256, 01 512, 10 1024 bytes, 11 reserved.
// - program buffer load address wraps at the selected page size.
// - page erase covers a dual page at 01 and a quad page at 10.
// - protection from complement plus level, or block locks when selected.
// - every block lock bit is set at power-on and after any reset.
// - register writes only accepted after write enable set the latch.
// - 01h and 31h write status; 11h writes configure.
// - status write never changes bits 15, 10, 1 and 0.
// - status write runs only if chip select rises after 8 or 16 data bits.
// - one-byte status write clears complement, quad enable and upper mode bit.
// - valid write starts timed busy cycle; end clears busy and latch.
// - no status write while hardware protected mode is in force.
// - configure write needs exactly 8 data bits, then the same busy cycle.
// - opcode C8h shifts the tuning register out msb first on falling edges.
// - tuning bit 7 selects dummy length, bit 3 enables learning pattern.
// - dummy clocks: dual read 4 or 8, quad read 6 or 10.
// - learning pattern 00110100 on every data line during dummy cycles.
// - tuning write is opcode 56h plus one byte, only with latch set.
// - tuning register clears at power-up and on every reset.
// - with the latch clear, register writes, program and erase are ignored.
// - latch clears on write disable, power-up and write completion.
`timescale 1ns/1ps
`default_nettype none
module sfc_config_regs #(
  parameter int STATUS_WRITE_TIME_US = 5000,
  parameter int NUM_BLOCK_LOCKS      = 16
) (
  input  wire logic                       mclk,
  input  wire logic                       rst,
  input  wire logic                       cs_n,
  input  wire logic                       sclk,
  input  wire logic                       si,
  input  wire logic                       wp_n,
  input  wire logic                       hold_reset_n,
  input  wire logic                       array_write_req,
  output logic                            so,
  output logic                            so_oe,
  output logic                            write_in_progress,
  output logic                            write_enable_latch,
  output logic [15:0]                     status_reg,
  output logic [7:0]                      device_config_reg,
  output logic [7:0]                      read_tuning_reg,
  output logic                            hold_function_en,
  output logic                            reset_function_en,
  output logic                            hold_active,
  output logic                            pin_reset,
  output logic                            quad_enable,
  output logic [1:0]                      drive_strength,
  output logic [7:0]                      drive_percent,
  output logic [1:0]                      page_size_select,
  output logic [9:0]                      page_wrap_mask,
  output logic [2:0]                      erase_page_count,
  output logic                            protect_scheme_select,
  output logic                            protect_complement,
  output logic [4:0]                      block_protect_level,
  output logic [NUM_BLOCK_LOCKS-1:0]      block_lock,
  output logic                            array_write_allowed,
  output logic [3:0]                      dual_dummy_clocks,
  output logic [3:0]                      quad_dummy_clocks,
  output logic                            learning_pattern_enable,
  output logic [7:0]                      learning_pattern
);
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int TW_CYCLES_RAW = (STATUS_WRITE_TIME_US * (sfc_pkg::MCLK_HZ / sfc_pkg::US_PER_S));
  localparam int TW_CYCLES     = (TW_CYCLES_RAW < 1) ? 1 : TW_CYCLES_RAW;
  localparam logic [31:0] TW_LAST = 32'(TW_CYCLES - 1);

  typedef enum logic [1:0] {
    SFC_OPCODE,
    SFC_DATA,
    SFC_READOUT,
    SFC_SKIP
  } sfc_state_t;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // first/second are the two candidate data bytes; two selects a 16-bit write
  function automatic logic [15:0] sfc_status_next(input logic [15:0] old,
                                                  input logic [7:0]  first,
                                                  input logic [7:0]  second,
                                                  input logic        two);
    logic [15:0] wr;
    wr = two ? {second, first} : {old[15:8] & ~sfc_pkg::ST_ONE_CLEAR[15:8], first};
    // lock bits are one-time: a write can only set them
    wr = wr | (old & sfc_pkg::ST_OTP_MASK);
    return (wr & ~sfc_pkg::ST_KEEP_MASK) | (old & sfc_pkg::ST_KEEP_MASK);
  endfunction : sfc_status_next

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pin_meta_q;
  logic [4:0] pin_sync_q;
  logic       sclk_prev_q;
  logic       cs_prev_q;

  always_ff @(posedge mclk) begin
    pin_meta_q <= {cs_n, sclk, si, wp_n, hold_reset_n};
    pin_sync_q <= pin_meta_q;
    sclk_prev_q <= pin_sync_q[3];
    cs_prev_q <= pin_sync_q[4];
  end

  wire cs_s    = pin_sync_q[4];
  wire sclk_s  = pin_sync_q[3];
  wire si_s    = pin_sync_q[2];
  wire wp_s    = pin_sync_q[1];
  wire shared_s = pin_sync_q[0];

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [15:0]                st_q;
  logic [7:0]                 cfg_q;
  logic [7:0]                 tun_q;
  logic                       wel_q;
  logic                       wip_q;
  logic [31:0]                tw_cnt_q;
  logic [NUM_BLOCK_LOCKS-1:0] lock_q;
  sfc_state_t                 state_q;
  logic [7:0]                 cmd_q;
  logic [4:0]                 bit_cnt_q;
  logic [15:0]                shift_in_q;
  logic [7:0]                 out_sh_q;
  logic                       so_q;

  // ----------------------------------------------------------------
  // shared pin and protection decode
  // ----------------------------------------------------------------
  wire qe_w       = st_q[sfc_pkg::ST_QE];
  wire hold_en_w  = ~qe_w & ~cfg_q[sfc_pkg::CFG_HOLD_RST];
  wire reset_en_w = ~qe_w & cfg_q[sfc_pkg::CFG_HOLD_RST];
  wire hold_w     = hold_en_w & ~shared_s;
  wire pin_rst_w  = reset_en_w & ~shared_s;
  wire vol_rst_w  = rst | pin_rst_w;
  // with quad enable set the write protect pin is a data line, so it reads as high
  wire wp_eff_w   = qe_w | wp_s;
  wire [1:0] srp_w = {st_q[sfc_pkg::ST_STATUS_PROTECT_MODE], st_q[sfc_pkg::ST_SRP0]};
  wire hw_prot_w  = (srp_w == sfc_pkg::SRP_HARDWARE) ? ~wp_eff_w : srp_w[1];

  // ----------------------------------------------------------------
  // serial edge detection
  // ----------------------------------------------------------------
  wire frame_w   = ~cs_s;
  wire sclk_rise = frame_w & ~hold_w & sclk_s & ~sclk_prev_q;
  wire sclk_fall = frame_w & ~hold_w & ~sclk_s & sclk_prev_q;
  wire cs_rise   = cs_s & ~cs_prev_q;
  wire [7:0] opcode_w = {shift_in_q[6:0], si_s};
  wire op_end_w  = sclk_rise & (bit_cnt_q == sfc_pkg::CNT_OPCODE_LAST);

  // ----------------------------------------------------------------
  // command decode at chip-select rise
  // ----------------------------------------------------------------
  wire in_data   = cs_rise & (state_q == SFC_DATA);
  wire cnt8_w    = bit_cnt_q == sfc_pkg::CNT_OPCODE_END;
  wire cnt16_w   = bit_cnt_q == sfc_pkg::CNT_ONE_BYTE;
  wire cnt24_w   = bit_cnt_q == sfc_pkg::CNT_TWO_BYTE;
  wire is_write_status_cmd_w = (cmd_q == sfc_pkg::OP_WRITE_STATUS) |
                   (cmd_q == sfc_pkg::OP_WRITE_STATUS2);
  wire is_write_config_cmd_w = cmd_q == sfc_pkg::OP_WRITE_CONFIG;
  wire do_write_enable_cmd   = in_data & cnt8_w & (cmd_q == sfc_pkg::OP_WRITE_ENABLE);
  wire do_wrdi   = in_data & cnt8_w & (cmd_q == sfc_pkg::OP_WRITE_DISABLE);
  wire do_write_status_cmd   = in_data & is_write_status_cmd_w & wel_q & ~hw_prot_w & (cnt16_w | cnt24_w);
  wire do_write_config_cmd   = in_data & is_write_config_cmd_w & wel_q & cnt16_w;
  wire do_wtun   = in_data & (cmd_q == sfc_pkg::OP_WRITE_TUNING) & wel_q & cnt16_w;
  wire tw_done   = wip_q & (tw_cnt_q == TW_LAST);
  wire cmd_ok_w  = ~wip_q & (opcode_w != sfc_pkg::OP_READ_TUNING);

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (vol_rst_w | cs_s) begin
      state_q <= SFC_OPCODE;
      bit_cnt_q <= '0;
    end else if (sclk_rise) begin
      if (bit_cnt_q != sfc_pkg::CNT_MAX) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
      if (op_end_w) begin
        if (opcode_w == sfc_pkg::OP_READ_CONFIG) begin
          state_q <= SFC_READOUT;
        end else if (opcode_w == sfc_pkg::OP_READ_TUNING) begin
          state_q <= wip_q ? SFC_SKIP : SFC_READOUT;
        end else begin
          // busy device ignores every other opcode until the cycle ends
          state_q <= cmd_ok_w ? SFC_DATA : SFC_SKIP;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cmd_q <= '0;
      shift_in_q <= '0;
    end else if (sclk_rise) begin
      shift_in_q <= {shift_in_q[14:0], si_s};
      if (op_end_w) begin
        cmd_q <= opcode_w;
      end
    end
  end

  // ----------------------------------------------------------------
  // serial output: msb first on falling edges
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      out_sh_q <= '0;
      so_q <= 1'b0;
    end else if (op_end_w) begin
      out_sh_q <= (opcode_w == sfc_pkg::OP_READ_CONFIG) ? cfg_q : tun_q;
    end else if (sclk_fall & (state_q == SFC_READOUT)) begin
      so_q <= out_sh_q[7];
      out_sh_q <= {out_sh_q[6:0], out_sh_q[7]};
    end
  end

  // ----------------------------------------------------------------
  // status register and write enable latch
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= sfc_pkg::ST_RESET;
    end else if (do_write_status_cmd) begin
      st_q <= sfc_status_next(st_q, shift_in_q[cnt24_w ? 15 : 7 -: 8], shift_in_q[7:0], cnt24_w);
    end
  end

  always_ff @(posedge mclk) begin
    if (vol_rst_w) begin
      wel_q <= 1'b0;
    end else if (do_write_enable_cmd) begin
      wel_q <= 1'b1;
    end else if (do_wrdi | do_wtun | tw_done) begin
      wel_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // self-timed write cycle
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      wip_q <= 1'b0;
      tw_cnt_q <= '0;
    end else if (do_write_status_cmd | do_write_config_cmd) begin
      wip_q <= 1'b1;
      tw_cnt_q <= '0;
    end else if (tw_done) begin
      wip_q <= 1'b0;
    end else if (wip_q) begin
      tw_cnt_q <= tw_cnt_q + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // configure and tuning registers
  // ----------------------------------------------------------------
  // a pin reset drops only the volatile page bits; the rest is nonvolatile
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_q <= sfc_pkg::CFG_RESET;
    end else if (pin_rst_w) begin
      cfg_q <= cfg_q & ~sfc_pkg::CFG_PAGE_MASK;
    end else if (do_write_config_cmd) begin
      cfg_q <= shift_in_q[7:0] & sfc_pkg::CFG_WRITE_MASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (vol_rst_w) begin
      tun_q <= sfc_pkg::TUN_RESET;
    end else if (do_wtun) begin
      tun_q <= shift_in_q[7:0] & sfc_pkg::TUN_WRITE_MASK;
    end
  end

  // lock mechanics live elsewhere; this block only presets them
  always_ff @(posedge mclk) begin
    if (vol_rst_w) begin
      lock_q <= '1;
    end
  end

  // ----------------------------------------------------------------
  // decoded configuration outputs
  // ----------------------------------------------------------------
  wire [1:0] drv_w  = cfg_q[sfc_pkg::CFG_DRV_HI:sfc_pkg::CFG_DRV_LO];
  wire [1:0] page_w = cfg_q[sfc_pkg::CFG_PAGE_HI:sfc_pkg::CFG_PAGE_LO];
  wire wps_w        = cfg_q[sfc_pkg::CFG_WPS];
  wire dc_w         = tun_q[sfc_pkg::TUN_DUMMY];
  wire dlp_w        = tun_q[sfc_pkg::TUN_PATTERN];

  assign drive_percent = (drv_w == sfc_pkg::DRV_100) ? sfc_pkg::PCT_100 :
                         (drv_w == sfc_pkg::DRV_150) ? sfc_pkg::PCT_150 :
                         (drv_w == sfc_pkg::DRV_200) ? sfc_pkg::PCT_200 :
                                                       sfc_pkg::PCT_50;
  // reserved page code falls back to the 256-byte behaviour
  assign page_wrap_mask = (page_w == sfc_pkg::PAGE_512)  ? sfc_pkg::WRAP_512 :
                          (page_w == sfc_pkg::PAGE_1024) ? sfc_pkg::WRAP_1024 :
                                                           sfc_pkg::WRAP_256;
  assign erase_page_count = (page_w == sfc_pkg::PAGE_512)  ? sfc_pkg::ERASE_DUAL :
                            (page_w == sfc_pkg::PAGE_1024) ? sfc_pkg::ERASE_QUAD :
                                                             sfc_pkg::ERASE_ONE;
  assign dual_dummy_clocks = dc_w ? sfc_pkg::DUAL_DUMMY_LONG : sfc_pkg::DUAL_DUMMY_SHORT;
  assign quad_dummy_clocks = dc_w ? sfc_pkg::QUAD_DUMMY_LONG : sfc_pkg::QUAD_DUMMY_SHORT;
  assign learning_pattern  = dlp_w ? sfc_pkg::LEARNING_PATTERN : 8'h00;
  assign array_write_allowed = array_write_req & wel_q & ~wip_q;

  // ----------------------------------------------------------------
  // port drive
  // ----------------------------------------------------------------
  assign so                      = so_q;
  assign so_oe                   = frame_w & ~hold_w & (state_q == SFC_READOUT);
  assign write_in_progress       = wip_q;
  assign write_enable_latch      = wel_q;
  assign status_reg              = {st_q[15:2], wel_q, wip_q};
  assign device_config_reg       = cfg_q;
  assign read_tuning_reg         = tun_q;
  assign hold_function_en        = hold_en_w;
  assign reset_function_en       = reset_en_w;
  assign hold_active             = hold_w;
  assign pin_reset               = pin_rst_w;
  assign quad_enable             = qe_w;
  assign drive_strength          = drv_w;
  assign page_size_select        = page_w;
  assign protect_scheme_select   = wps_w;
  assign protect_complement      = wps_w ? 1'b0 : st_q[sfc_pkg::ST_CMP];
  assign block_protect_level     = wps_w ? 5'h00 : st_q[sfc_pkg::ST_BP_HI:sfc_pkg::ST_BP_LO];
  assign block_lock              = wps_w ? lock_q : '0;
  assign learning_pattern_enable = dlp_w;
endmodule : sfc_config_regs
`default_nettype wire

// ---- rtl/sfc_pkg.sv ----
/*
  constants for the serial flash configuration register block: opcodes,
  field positions, reset values, decode tables and timing.
  assumes a single mclk domain; nothing else.
*/
package sfc_pkg;
  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_READ_CONFIG   = 8'h15;
  localparam logic [7:0] OP_WRITE_STATUS  = 8'h01;
  localparam logic [7:0] OP_WRITE_STATUS2 = 8'h31;
  localparam logic [7:0] OP_WRITE_CONFIG  = 8'h11;
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_TUNING   = 8'hC8;
  localparam logic [7:0] OP_WRITE_TUNING  = 8'h56;
  // ----------------------------------------------------------------
  // frame bit counts
  // ----------------------------------------------------------------
  localparam logic [4:0] CNT_OPCODE_LAST = 5'h07;
  localparam logic [4:0] CNT_OPCODE_END  = 5'h08;
  localparam logic [4:0] CNT_ONE_BYTE    = 5'h10;
  localparam logic [4:0] CNT_TWO_BYTE    = 5'h18;
  localparam logic [4:0] CNT_MAX         = 5'h1F;
  // ----------------------------------------------------------------
  // configure register
  // ----------------------------------------------------------------
  localparam int CFG_HOLD_RST = 7;
  localparam int CFG_DRV_HI   = 6;
  localparam int CFG_DRV_LO   = 5;
  localparam int CFG_PAGE_HI  = 4;
  localparam int CFG_PAGE_LO  = 3;
  localparam int CFG_WPS      = 2;
  localparam logic [7:0] CFG_RESET      = 8'h40;
  localparam logic [7:0] CFG_WRITE_MASK = 8'hFC;
  localparam logic [7:0] CFG_PAGE_MASK  = 8'h18;
  // ----------------------------------------------------------------
  // read tuning register
  // ----------------------------------------------------------------
  localparam int TUN_DUMMY   = 7;
  localparam int TUN_PATTERN = 3;
  localparam logic [7:0] TUN_RESET      = 8'h00;
  localparam logic [7:0] TUN_WRITE_MASK = 8'h88;
  // ----------------------------------------------------------------
  // status register
  // ----------------------------------------------------------------
  localparam int ST_CMP   = 14;
  localparam int ST_QE    = 9;
  localparam int ST_STATUS_PROTECT_MODE  = 8;
  localparam int ST_SRP0  = 7;
  localparam int ST_BP_HI = 6;
  localparam int ST_BP_LO = 2;
  localparam logic [15:0] ST_RESET     = 16'h0000;
  localparam logic [15:0] ST_KEEP_MASK = 16'h8403;
  localparam logic [15:0] ST_OTP_MASK  = 16'h3800;
  localparam logic [15:0] ST_ONE_CLEAR = 16'h4300;
  localparam logic [1:0]  SRP_HARDWARE = 2'b01;
  // ----------------------------------------------------------------
  // decode tables
  // ----------------------------------------------------------------
  localparam logic [1:0] PAGE_256  = 2'b00;
  localparam logic [1:0] PAGE_512  = 2'b01;
  localparam logic [1:0] PAGE_1024 = 2'b10;
  localparam logic [9:0] WRAP_256  = 10'h0FF;
  localparam logic [9:0] WRAP_512  = 10'h1FF;
  localparam logic [9:0] WRAP_1024 = 10'h3FF;
  localparam logic [2:0] ERASE_ONE  = 3'h1;
  localparam logic [2:0] ERASE_DUAL = 3'h2;
  localparam logic [2:0] ERASE_QUAD = 3'h4;
  localparam logic [1:0] DRV_100 = 2'b00;
  localparam logic [1:0] DRV_150 = 2'b01;
  localparam logic [1:0] DRV_200 = 2'b10;
  localparam logic [7:0] PCT_50  = 8'h32;
  localparam logic [7:0] PCT_100 = 8'h64;
  localparam logic [7:0] PCT_150 = 8'h96;
  localparam logic [7:0] PCT_200 = 8'hC8;
  localparam logic [3:0] DUAL_DUMMY_SHORT = 4'h4;
  localparam logic [3:0] DUAL_DUMMY_LONG  = 4'h8;
  localparam logic [3:0] QUAD_DUMMY_SHORT = 4'h6;
  localparam logic [3:0] QUAD_DUMMY_LONG  = 4'hA;
  localparam logic [7:0] LEARNING_PATTERN = 8'h34;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int MCLK_HZ = 10000000;
  localparam int US_PER_S = 1000000;
endpackage : sfc_pkg

// ---- tb/sfc_checker_assertions.sv ----
/* port checker for the config block; assumes the one mclk domain */
`timescale 1ns/1ps
`default_nettype none
module sfc_checker_assertions #(
  parameter int BUSY_US = 1
) (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        write_in_progress,
  input wire logic        write_enable_latch,
  input wire logic        quad_enable,
  input wire logic        hold_function_en,
  input wire logic        learning_pattern_enable,
  input wire logic [15:0] status_reg,
  input wire logic [7:0]  device_config_reg,
  input wire logic [7:0]  read_tuning_reg,
  input wire logic [7:0]  drive_percent,
  input wire logic [7:0]  learning_pattern,
  input wire logic [1:0]  drive_strength,
  input wire logic [1:0]  page_size_select,
  input wire logic [9:0]  page_wrap_mask,
  input wire logic [3:0]  dual_dummy_clocks
);
  // busy length follows the write time of the bound instance
  localparam int BUSY_CYCLES = BUSY_US * (sfc_pkg::MCLK_HZ / sfc_pkg::US_PER_S);
  logic [31:0] busy_cnt_q;
  always_ff @(posedge mclk) begin
    if (rst || !write_in_progress) begin
      busy_cnt_q <= '0;
    end else begin
      busy_cnt_q <= busy_cnt_q + 32'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence busy_hold;
    write_in_progress[*8];
  endsequence
  a_hold_select: assert property (hold_function_en == (!quad_enable && !device_config_reg[7]))
    else $error("hold select wrong");
  a_drive_table: assert property (drive_percent == (drive_strength == 2'b00 ? 8'h64 :
    drive_strength == 2'b01 ? 8'h96 : drive_strength == 2'b10 ? 8'hC8 : 8'h32)) else $error("drive");
  a_page_wrap: assert property (page_wrap_mask == (page_size_select == 2'b01 ? 10'h1FF :
    page_size_select == 2'b10 ? 10'h3FF : 10'h0FF)) else $error("page wrap wrong");
  a_dummy_len: assert property (dual_dummy_clocks == (read_tuning_reg[7] ? 4'h8 : 4'h4))
    else $error("dummy count wrong");
  a_pattern_out: assert property (learning_pattern == (learning_pattern_enable ? 8'h34 : 8'h00))
    else $error("pattern wrong");
  a_reserved_zero: assert property (device_config_reg[1:0] == 2'b00 &&
    (read_tuning_reg & 8'h77) == 8'h00) else $error("reserved bit set");
  a_status_fixed: assert property ($stable({status_reg[15], status_reg[10]}))
    else $error("fixed status bit moved");
  a_write_wel: assert property ($rose(write_in_progress) |-> $past(write_enable_latch))
    else $error("write without latch");
  a_busy_span: assert property ($rose(write_in_progress) |-> busy_hold)
    else $error("busy span wrong");
  a_busy_length: assert property ($fell(write_in_progress) |->
    (busy_cnt_q == BUSY_CYCLES) && !write_enable_latch) else $error("busy length wrong");
endmodule : sfc_checker_assertions
bind sfc_config_regs sfc_checker_assertions #(.BUSY_US(STATUS_WRITE_TIME_US)) chk (.*);
`default_nettype wire

// ---- tb/sfc_ctrl_model.sv ----
/* serial controller model; sclk idles low between frames, si inverts when released */
`timescale 1ns/1ps
`default_nettype none
module sfc_ctrl_model (
  input  wire logic mclk,
  input  wire logic so,
  output logic      cs_n,
  output logic      sclk,
  output logic      si
);
  logic [7:0] rd;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si   = 1'b0;
    rd   = 8'h00;
  end
  // so sampled just before the fall, where the previous bit is settled
  task automatic frame(input logic [23:0] d, input int n);
    @(posedge mclk) cs_n <= 1'b0;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      si <= d[23-i];
      repeat (4) @(posedge mclk);
      sclk <= 1'b1;
      repeat (4) @(posedge mclk);
      rd   <= {rd[6:0], so};
      sclk <= 1'b0;
    end
    repeat (3) @(posedge mclk);
    si   <= ~si;
    cs_n <= 1'b1;
    repeat (6) @(posedge mclk);
  endtask : frame
endmodule : sfc_ctrl_model
`default_nettype wire

// ---- tb/tb_top.sv ----
/* self-checking bench for sfc_config_regs; drives the link through the controller model */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk, rst, cs_n, sclk, si, wp_n, hold_reset_n, array_write_req, so, so_oe, hold_active;
  logic write_in_progress, write_enable_latch, hold_function_en, reset_function_en, pin_reset;
  logic quad_enable, protect_scheme_select, protect_complement, array_write_allowed;
  logic learning_pattern_enable;
  logic [15:0] status_reg, block_lock;
  logic [7:0]  device_config_reg, read_tuning_reg, drive_percent, learning_pattern, d, t;
  logic [1:0]  drive_strength, page_size_select;
  logic [9:0]  page_wrap_mask;
  logic [2:0]  erase_page_count;
  logic [4:0]  block_protect_level;
  logic [3:0]  dual_dummy_clocks, quad_dummy_clocks;
  int          n_fail, comparisons, seed;
  // a 200 mclk busy cycle outlasts a whole read frame, so reads land while busy
  sfc_config_regs #(.STATUS_WRITE_TIME_US(20)) uut (.*);
  sfc_ctrl_model ctl (.mclk(mclk), .so(so), .cs_n(cs_n), .sclk(sclk), .si(si));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  function automatic logic [7:0] pct(input logic [1:0] s);
    return s == 2'b00 ? 8'h64 : s == 2'b01 ? 8'h96 : s == 2'b10 ? 8'hC8 : 8'h32;
  endfunction : pct
  function automatic logic [15:0] pages(input logic [1:0] s);
    return s == 2'b01 ? 16'h0002 : s == 2'b10 ? 16'h0004 : 16'h0001;
  endfunction : pages
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic close_out();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  task automatic idle();
    int i;
    for (i = 0; i < 300 && write_in_progress !== 1'b0; i++) @(posedge mclk);
    if (i == 300) begin
      chk("idle", 16'h0000, {15'h0000, write_in_progress});
      close_out();
    end
  endtask : idle
  // latch set first: writes without it are dropped
  task automatic wr(input logic [23:0] f, input int n);
    idle();
    ctl.frame(24'h060000, 8);
    ctl.frame(f, n);
  endtask : wr
  initial begin
    seed = 32'hDA53; n_fail = 0; comparisons = 0;
    rst = 1'b1; wp_n = 1'b1; hold_reset_n = 1'b1; array_write_req = 1'b0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("cfg", 16'h0040, device_config_reg);
    chk("tuning", 16'h0000, read_tuning_reg);
    chk("locks", 16'h0000, block_lock);
    ctl.frame({8'h11, 8'hFF, 8'h00}, 16);
    chk("cfg", 16'h0040, device_config_reg);
    for (int k = 0; k < 6; k++) begin
      d = $random(seed);
      t = $random(seed);
      array_write_req <= d[0];
      wr({8'h11, d, 8'h00}, 16);
      chk("busy", 16'h0001, write_in_progress);
      ctl.frame({8'h15, 16'h0000}, 16);
      chk("cfg read", d & 8'hFC, ctl.rd);
      idle();
      chk("wel", 16'h0000, write_enable_latch);
      chk("cfg", d & 8'hFC, device_config_reg);
      chk("drive", pct(d[6:5]), drive_percent);
      chk("erase", pages(d[4:3]), erase_page_count);
      chk("reset pin", {15'h0000, d[7]}, reset_function_en);
      wr({8'h56, t, 8'h00}, 16);
      chk("tuning", t & 8'h88, read_tuning_reg);
      chk("dummy", t[7] ? 8'h0A : 8'h06, quad_dummy_clocks);
      ctl.frame({8'hC8, 16'h0000}, 16);
      chk("tuning read", t & 8'h88, ctl.rd);
    end
    array_write_req <= 1'b1;
    wr({8'h11, 8'h00, 8'h00}, 12);
    chk("cfg kept", d & 8'hFC, device_config_reg);
    chk("allow", 16'h0001, array_write_allowed);
    ctl.frame(24'h040000, 8);
    chk("wel off", 16'h0000, write_enable_latch);
    chk("allow off", 16'h0000, array_write_allowed);
    wr({8'h31, 8'h7F, 8'hC6}, 24);
    idle();
    chk("status", 16'h427C, status_reg & 16'hFFFC);
    chk("level", d[2] ? 16'h0000 : 16'h001F, block_protect_level);
    chk("quad", 16'h0000, {hold_function_en, reset_function_en});
    wr({8'h01, 8'h80, 8'h00}, 16);
    idle();
    chk("status", 16'h0080, status_reg);
    wp_n <= 1'b0;
    wr({8'h01, 8'h00, 8'h00}, 16);
    chk("protected", 16'h0080, status_reg & 16'hFFFC);
    wp_n <= 1'b1;
    wr({8'h11, 8'hDC, 8'h00}, 16);
    wr({8'h56, 8'h88, 8'h00}, 16);
    hold_reset_n <= 1'b0;
    repeat (4) @(posedge mclk);
    hold_reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("cfg kept", 16'h00C4, device_config_reg);
    chk("tuning", 16'h0000, read_tuning_reg);
    chk("locks", 16'hFFFF, block_lock);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
